// file: logic/timer8_pwm_pkg.sv
// constants shared by the 8-bit pwm timer and its output channels
// assumes one clock domain; software reaches the registers over avalon-mm
package timer8_pwm_pkg;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_CMPA = 5'h04;
    localparam logic [4:0] OFF_CMPB = 5'h08;
    localparam logic [4:0] OFF_COUNT = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;

    // control register fields
    localparam int MODE_LSB = 0;
    localparam int ACTB_LSB = 4;
    localparam int ACTA_LSB = 6;
    // status register fields
    localparam int OVF_BIT = 0;
    localparam int CMPA_BIT = 1;
    localparam int CMPB_BIT = 2;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;

    localparam logic [2:0] MODE_PC_MAX = 3'h1;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_PC_CMPA = 3'h5;
    localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;

    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
endpackage : timer8_pwm_pkg

// file: logic/wave_channel.sv
// one compare output channel: next level of the wave output per tick
// assumes the caller gates tick with its clock enable and supplies match timing
`timescale 1ns/1ps
`default_nettype none
module wave_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic fastMode,
    input wire logic pcMode,
    input wire logic toggleOk,
    input wire logic [1:0] action,
    input wire logic [7:0] count,
    input wire logic [7:0] cmp,
    input wire logic [7:0] top,
    input wire logic atTop,
    input wire logic dirUp,
    input wire logic noMatch,
    output logic wave
);
    logic waveNext;
    wire logic match = (count == cmp) && !noMatch;
    wire logic inv = (action == timer8_pwm_pkg::ACT_INV);
    wire logic pwmAct = action[1];
    wire logic toggle = (action == timer8_pwm_pkg::ACT_TOGGLE) && toggleOk;
    // bottom counts as up-going so compare zero never makes a spike in phase correct
    wire logic upward = dirUp || (count == timer8_pwm_pkg::COUNT_BOTTOM);

    // level an up-counting match leaves behind
    function automatic logic upLevel(input logic inverted);
        upLevel = inverted;
    endfunction : upLevel

    always_comb begin
        waveNext = wave;
        if (toggle && match && (fastMode || pcMode)) begin
            waveNext = !wave;
        end else if (pwmAct && fastMode) begin
            if (atTop) begin
                waveNext = !upLevel(inv);
            end else if (match) begin
                waveNext = upLevel(inv);
            end
        end else if (pwmAct && pcMode) begin
            if (atTop && dirUp) begin
                // at top: a compare equal to top keeps the down level, else the up result
                waveNext = (cmp == top) ? !upLevel(inv) : upLevel(inv);
            end else if (match) begin
                waveNext = upward ? upLevel(inv) : !upLevel(inv);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave <= 1'b0;
        end else if (tick) begin
            wave <= waveNext;
        end
    end
endmodule : wave_channel
`default_nettype wire

// file: logic/timer8_pwm.sv
// 8-bit timer with fast and phase correct pwm, two compare output channels
// assumes timerTick comes from a prescaler on ref_clk; avalon-mm slave with waitrequest
`timescale 1ns/1ps
`default_nettype none
module timer8_pwm (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic timerTick,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic waveOutA,
    output logic waveOutB,
    output logic overrideA,
    output logic overrideB,
    output logic overflowFlag
);
    logic rstPipe_n;
    logic rstSync_n;
    logic [7:0] ctrl_reg;
    logic [7:0] cmpABuf_reg;
    logic [7:0] cmpBBuf_reg;
    logic [7:0] cmpA_reg;
    logic [7:0] cmpB_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic dirUp_reg;
    logic dirUp_next;
    logic block_reg;
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic [31:0] readdata_reg;
    logic wait_reg;
    logic overrideA_reg;
    logic overrideB_reg;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstPipe_n <= 1'b1;
            rstSync_n <= rstPipe_n;
        end
    end

    // mode decode
    wire logic [2:0] mode = ctrl_reg[timer8_pwm_pkg::MODE_LSB +: 3];
    wire logic [1:0] actA = ctrl_reg[timer8_pwm_pkg::ACTA_LSB +: 2];
    wire logic [1:0] actB = ctrl_reg[timer8_pwm_pkg::ACTB_LSB +: 2];
    wire logic fastMode = (mode == timer8_pwm_pkg::MODE_FAST_MAX)
        || (mode == timer8_pwm_pkg::MODE_FAST_CMPA);
    wire logic pcMode = (mode == timer8_pwm_pkg::MODE_PC_MAX)
        || (mode == timer8_pwm_pkg::MODE_PC_CMPA);
    wire logic pwmMode = fastMode || pcMode;
    // modes 5 and 7 take top from compare a, 1 and 3 from the 8-bit maximum
    wire logic [7:0] top = mode[2] ? cmpA_reg : timer8_pwm_pkg::COUNT_MAX;
    wire logic tick = clkEn && timerTick;
    wire logic atTop = (count_reg == top);
    wire logic atBottom = (count_reg == timer8_pwm_pkg::COUNT_BOTTOM);
    // compare buffers load at top (phase correct) or at the wrap (fast)
    wire logic updPoint = !pwmMode || (tick && atTop && dirUp_reg);
    // at the update tick the channels already judge against the incoming value
    wire logic [7:0] cmpAEff = updPoint ? cmpABuf_reg : cmpA_reg;
    wire logic [7:0] cmpBEff = updPoint ? cmpBBuf_reg : cmpB_reg;

    // bus decode; an access completes in the cycle waitrequest is low
    wire logic access = (read || write) && !wait_reg;
    wire logic wrEn = write && !wait_reg;
    wire logic wrCtrl = wrEn && (address == timer8_pwm_pkg::OFF_CTRL);
    wire logic wrCmpA = wrEn && (address == timer8_pwm_pkg::OFF_CMPA);
    wire logic wrCmpB = wrEn && (address == timer8_pwm_pkg::OFF_CMPB);
    wire logic wrCount = wrEn && (address == timer8_pwm_pkg::OFF_COUNT);
    wire logic wrStatus = wrEn && (address == timer8_pwm_pkg::OFF_STATUS);
    wire logic [31:0] readValue =
        (address == timer8_pwm_pkg::OFF_CTRL) ? {24'h000000, ctrl_reg} :
        (address == timer8_pwm_pkg::OFF_CMPA) ? {24'h000000, cmpABuf_reg} :
        (address == timer8_pwm_pkg::OFF_CMPB) ? {24'h000000, cmpBBuf_reg} :
        (address == timer8_pwm_pkg::OFF_COUNT) ? {24'h000000, count_reg} :
        (address == timer8_pwm_pkg::OFF_STATUS) ? {29'h00000000, status_reg} :
        32'h00000000;

    // counter sequencing
    wire logic [7:0] countInc = count_reg + 8'h01;
    wire logic [7:0] countDec = count_reg - 8'h01;
    always_comb begin
        count_next = count_reg;
        dirUp_next = dirUp_reg;
        if (fastMode) begin
            count_next = atTop ? timer8_pwm_pkg::COUNT_BOTTOM : countInc;
            dirUp_next = 1'b1;
        end else if (pcMode) begin
            if (dirUp_reg) begin
                // top stands for this one tick, then the count turns down
                count_next = atTop ? (atBottom ? count_reg : countDec) : countInc;
                dirUp_next = !atTop;
            end else begin
                count_next = atBottom ? (atTop ? count_reg : countInc) : countDec;
                dirUp_next = atBottom;
            end
        end
    end

    // sticky flags; a set in the same cycle as a clear wins
    wire logic ovfSet = tick && ((fastMode && atTop) || (pcMode && !dirUp_reg && atBottom));
    wire logic matchA = tick && pwmMode && !block_reg && (count_reg == cmpAEff);
    wire logic matchB = tick && pwmMode && !block_reg && (count_reg == cmpBEff);
    wire logic [2:0] setBits = {matchB, matchA, ovfSet};
    wire logic [2:0] clrBits = wrStatus ? writedata[2:0] : 3'h0;
    assign status_next = (status_reg & ~clrBits) | setBits;

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count_reg <= timer8_pwm_pkg::COUNT_RESET;
            dirUp_reg <= 1'b1;
            block_reg <= 1'b0;
        end else if (clkEn) begin
            if (wrCount) begin
                count_reg <= writedata[7:0];
            end else if (tick) begin
                count_reg <= count_next;
                dirUp_reg <= dirUp_next;
            end
            // a counter write masks compare matches for the following tick
            block_reg <= wrCount || (block_reg && !tick);
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl_reg <= timer8_pwm_pkg::CTRL_RESET;
            cmpABuf_reg <= timer8_pwm_pkg::CMP_RESET;
            cmpBBuf_reg <= timer8_pwm_pkg::CMP_RESET;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_reg <= {writedata[7:4], 1'b0, writedata[2:0]};
            end
            if (wrCmpA) begin
                cmpABuf_reg <= writedata[7:0];
            end
            if (wrCmpB) begin
                cmpBBuf_reg <= writedata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cmpA_reg <= timer8_pwm_pkg::CMP_RESET;
            cmpB_reg <= timer8_pwm_pkg::CMP_RESET;
        end else if (clkEn && updPoint) begin
            cmpA_reg <= cmpABuf_reg;
            cmpB_reg <= cmpBBuf_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            status_reg <= timer8_pwm_pkg::STATUS_RESET;
            readdata_reg <= 32'h00000000;
            wait_reg <= 1'b1;
            overrideA_reg <= 1'b0;
            overrideB_reg <= 1'b0;
        end else if (clkEn) begin
            status_reg <= status_next;
            readdata_reg <= readValue;
            wait_reg <= !((read || write) && wait_reg);
            // pin override only; the pin direction stays with software
            overrideA_reg <= (actA != timer8_pwm_pkg::ACT_OFF);
            overrideB_reg <= (actB != timer8_pwm_pkg::ACT_OFF);
        end
    end

    wave_channel chanA (
        .clk(ref_clk),
        .rst_n(rstSync_n),
        .tick(tick),
        .fastMode(fastMode),
        .pcMode(pcMode),
        .toggleOk(mode[2]),
        .action(actA),
        .count(count_reg),
        .cmp(cmpAEff),
        .top(top),
        .atTop(atTop),
        .dirUp(dirUp_reg),
        .noMatch(block_reg),
        .wave(waveOutA)
    );

    // channel b has no toggle option
    wave_channel chanB (
        .clk(ref_clk),
        .rst_n(rstSync_n),
        .tick(tick),
        .fastMode(fastMode),
        .pcMode(pcMode),
        .toggleOk(1'b0),
        .action(actB),
        .count(count_reg),
        .cmp(cmpBEff),
        .top(top),
        .atTop(atTop),
        .dirUp(dirUp_reg),
        .noMatch(block_reg),
        .wave(waveOutB)
    );

    assign readdata = readdata_reg;
    assign waitrequest = wait_reg;
    assign overrideA = overrideA_reg;
    assign overrideB = overrideB_reg;
    assign overflowFlag = status_reg[timer8_pwm_pkg::OVF_BIT];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstSync_n);

    a_fast_wrap_zero: assert property (
        tick && fastMode && atTop && !wrCount |=> count_reg == 8'h00)
        else $error("fast pwm counter did not wrap to zero");
    a_fast_count_up: assert property (
        tick && fastMode && !atTop && !wrCount |=> count_reg == $past(count_reg) + 8'h01)
        else $error("fast pwm counter did not increment");
    a_fast_ovf_set: assert property (
        tick && fastMode && atTop |=> overflowFlag)
        else $error("overflow flag missing at top in fast pwm");
    a_fast_top_level: assert property (
        tick && fastMode && atTop && actA == timer8_pwm_pkg::ACT_NONINV |=> waveOutA)
        else $error("non-inverted fast pwm not set at wrap");
    a_fast_spike_len: assert property (
        tick && fastMode && atTop && actA == timer8_pwm_pkg::ACT_NONINV && cmpAEff == 8'h00
        && !mode[2] && !wrCount ##1 tick && fastMode && !mode[2] && !block_reg
        && actA == timer8_pwm_pkg::ACT_NONINV |=> !waveOutA)
        else $error("fast pwm spike not cleared after one tick");
    a_pc_turn_down: assert property (
        tick && pcMode && dirUp_reg && atTop && !atBottom && !wrCount
        |=> !dirUp_reg && count_reg == $past(count_reg) - 8'h01)
        else $error("phase correct counter did not turn at top");
    a_pc_ovf_bottom: assert property (
        tick && pcMode && !dirUp_reg && atBottom |=> overflowFlag && dirUp_reg)
        else $error("phase correct bottom missed overflow or turn");
    a_pc_up_clear: assert property (
        tick && pcMode && dirUp_reg && !atTop && matchA
        && actA == timer8_pwm_pkg::ACT_NONINV |=> !waveOutA)
        else $error("non-inverted up match did not clear");
    a_pc_max_high: assert property (
        tick && pcMode && dirUp_reg && atTop && cmpAEff == top
        && actA == timer8_pwm_pkg::ACT_NONINV |=> waveOutA)
        else $error("compare at top did not give high level");
    a_tick_only_count: assert property (
        !tick && !wrCount |=> $stable(count_reg))
        else $error("counter moved without a tick");
    a_cmp_buffered: assert property (
        pwmMode && !updPoint && clkEn |=> $stable(cmpA_reg) && $stable(cmpB_reg))
        else $error("active compare changed outside the update point");
    a_bus_one_wait: assert property (
        (read || write) && waitrequest && clkEn |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not given after one wait cycle");
    // the answer closes after one cycle so back-to-back access stays at two cycles
    a_bus_answer_end: assert property (
        access && clkEn |=> waitrequest)
        else $error("waitrequest did not rise after the answer cycle");
    a_fast_inv_top: assert property (
        tick && fastMode && atTop && actA == timer8_pwm_pkg::ACT_INV |=> !waveOutA)
        else $error("inverted fast pwm not cleared at wrap");
    a_fast_cmpa_top: assert property (
        tick && mode == timer8_pwm_pkg::MODE_FAST_CMPA && count_reg == cmpA_reg && !wrCount
        |=> count_reg == 8'h00)
        else $error("fast pwm with compare a top did not wrap there");
    a_pc_down_set: assert property (
        tick && pcMode && !dirUp_reg && !atBottom && matchA
        && actA == timer8_pwm_pkg::ACT_NONINV |=> waveOutA)
        else $error("non-inverted down match did not set");
    a_pc_inv_up: assert property (
        tick && pcMode && dirUp_reg && !atTop && matchA
        && actA == timer8_pwm_pkg::ACT_INV |=> waveOutA)
        else $error("inverted up match did not set");
    a_pc_ovf_away: assert property (
        tick && pcMode && !atBottom && !overflowFlag |=> !overflowFlag)
        else $error("phase correct overflow set away from bottom");
    a_pc_min_low: assert property (
        tick && pcMode && cmpAEff == 8'h00 && top != 8'h00 && !waveOutA
        && actA == timer8_pwm_pkg::ACT_NONINV |=> !waveOutA)
        else $error("compare zero let the non-inverted output rise");
    a_chan_b_hold: assert property (
        tick && pwmMode && actB == timer8_pwm_pkg::ACT_TOGGLE |=> $stable(waveOutB))
        else $error("channel b toggled although it has no toggle action");
    a_toggle_a_flip: assert property (
        tick && matchA && actA == timer8_pwm_pkg::ACT_TOGGLE && mode[2]
        |=> waveOutA != $past(waveOutA))
        else $error("channel a did not toggle on a match");

    c_fast_wrap: cover property (tick && fastMode && atTop);
    c_pc_turn: cover property (tick && pcMode && dirUp_reg && atTop);
    c_toggle_a: cover property (tick && matchA && actA == timer8_pwm_pkg::ACT_TOGGLE && mode[2]);
    c_flag_clear_race: cover property (wrStatus && writedata[0] && ovfSet);
    c_pc_bottom: cover property (tick && pcMode && !dirUp_reg && atBottom);
endmodule : timer8_pwm
`default_nettype wire

// file: sim/tb_timer8_pwm.sv
// self-checking bench for the 8-bit pwm timer: a cycle model beside the design
// assumes the design top timer8_pwm, its package, and a 25 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
module tb_timer8_pwm;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic timerTick = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest, waveOutA, waveOutB, overrideA, overrideB, overflowFlag;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic checking = 1'b0;
    // model state, written from the rules
    logic [7:0] mCtrl, mBufA, mBufB, mCmpA, mCmpB, mCnt;
    logic mUp, mWaveA, mWaveB, mOvf, mOvrA, mOvrB;

    timer8_pwm u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
        .timerTick(timerTick), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .waveOutA(waveOutA), .waveOutB(waveOutB), .overrideA(overrideA),
        .overrideB(overrideB), .overflowFlag(overflowFlag));

    always #20 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    function automatic logic wave_next(input logic w, input logic [1:0] act, input logic tog,
        input logic fast, input logic match, input logic atTop, input logic cmpTop,
        input logic up);
        logic lvl;
        lvl = (act == timer8_pwm_pkg::ACT_INV);
        if (act == timer8_pwm_pkg::ACT_TOGGLE) return (tog && match) ? !w : w;
        if (act == timer8_pwm_pkg::ACT_OFF) return w;
        if (fast) return atTop ? !lvl : (match ? lvl : w);
        if (atTop) return cmpTop ? !lvl : lvl;
        return match ? (up ? lvl : !lvl) : w;
    endfunction : wave_next

    task automatic model_tick();
        logic [2:0] m;
        logic fast, atTop, up;
        logic [7:0] t;
        m = mCtrl[2:0];
        fast = (m == timer8_pwm_pkg::MODE_FAST_MAX) || (m == timer8_pwm_pkg::MODE_FAST_CMPA);
        if (!fast && m != timer8_pwm_pkg::MODE_PC_MAX && m != timer8_pwm_pkg::MODE_PC_CMPA) return;
        t = m[2] ? mCmpA : 8'hFF;
        atTop = (mCnt == t) && (fast || mUp);
        if (atTop) begin
            mCmpA = mBufA;
            mCmpB = mBufB;
        end
        up = mUp || (mCnt == 8'h00);
        mWaveA = wave_next(mWaveA, mCtrl[7:6], m[2], fast, mCnt == mCmpA, atTop, mCmpA == t, up);
        mWaveB = wave_next(mWaveB, mCtrl[5:4], 1'b0, fast, mCnt == mCmpB, atTop, mCmpB == t, up);
        if (fast) begin
            mOvf = mOvf | atTop;
            mCnt = atTop ? 8'h00 : mCnt + 8'h01;
        end else begin
            if (mCnt == 8'h00 && !mUp) mOvf = 1'b1;
            if (atTop) mUp = 1'b0;
            else if (mCnt == 8'h00) mUp = 1'b1;
            mCnt = mUp ? mCnt + 8'h01 : mCnt - 8'h01;
        end
    endtask : model_tick

    task automatic model_write();
        case (address)
            timer8_pwm_pkg::OFF_CTRL: mCtrl = writedata[7:0] & 8'hF7;
            timer8_pwm_pkg::OFF_CMPA: mBufA = writedata[7:0];
            timer8_pwm_pkg::OFF_CMPB: mBufB = writedata[7:0];
            timer8_pwm_pkg::OFF_COUNT: mCnt = writedata[7:0];
            timer8_pwm_pkg::OFF_STATUS: if (writedata[0]) mOvf = 1'b0;
            default: ;
        endcase
        if (mCtrl[1:0] == 2'h0 || mCtrl[1:0] == 2'h2) begin
            mCmpA = mBufA;
            mCmpB = mBufB;
        end
    endtask : model_write

    function automatic logic [31:0] exp_read(input logic [4:0] a);
        case (a)
            timer8_pwm_pkg::OFF_CTRL: return {24'h000000, mCtrl};
            timer8_pwm_pkg::OFF_CMPA: return {24'h000000, mBufA};
            timer8_pwm_pkg::OFF_CMPB: return {24'h000000, mBufB};
            timer8_pwm_pkg::OFF_COUNT: return {24'h000000, mCnt};
            timer8_pwm_pkg::OFF_STATUS: return {31'h00000000, mOvf};
            default: return 32'h00000000;
        endcase
    endfunction : exp_read

    // compare first, so the check sees the state from before this edge
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            {mCtrl, mBufA, mBufB, mCmpA, mCmpB, mCnt} = 48'h000000000000;
            {mWaveA, mWaveB, mOvf, mUp, mOvrA, mOvrB} = 6'h04;
        end
        if (checking) cmp({27'h0000000, waveOutA, waveOutB, overrideA, overrideB, overflowFlag},
            {27'h0000000, mWaveA, mWaveB, mOvrA, mOvrB, mOvf});
        // the pin override follows the control value of the cycle before
        if (reset_n && clkEn) {mOvrA, mOvrB} = {mCtrl[7:6] != 2'h0, mCtrl[5:4] != 2'h0};
        if (reset_n && clkEn && write && !waitrequest) model_write();
        else if (reset_n && clkEn && timerTick) model_tick();
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        timerTick <= 1'b0;
        clkEn <= 1'b1;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) begin
            bad_count++;
            close_out();
        end
    endtask : bus

    task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : bus_write

    task automatic check_read(input logic [4:0] a);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        // status compare flags are not modelled, so those two bits are masked
        cmp(a == timer8_pwm_pkg::OFF_STATUS ? q & 32'hFFFFFFF9 : q, exp_read(a));
    endtask : check_read

    task automatic reset_dut();
        timerTick <= 1'b0;
        clkEn <= 1'b1;
        reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : reset_dut

    task automatic setup(input logic [2:0] m, input logic [1:0] aA, input logic [1:0] aB,
        input logic [7:0] ca, input logic [7:0] cb);
        reset_dut();
        bus_write(timer8_pwm_pkg::OFF_CMPA, {24'h000000, ca});
        bus_write(timer8_pwm_pkg::OFF_CMPB, {24'h000000, cb});
        bus_write(timer8_pwm_pkg::OFF_CTRL, {24'h000000, aA, aB, 1'b0, m});
    endtask : setup

    // pct is the tick rate in percent; jitter also drops clkEn now and then
    task automatic run(input int n, input int pct, input logic jitter);
        repeat (n) begin
            timerTick <= ($urandom % 100) < pct;
            clkEn <= jitter ? (($urandom % 8) != 0) : 1'b1;
            @(posedge ref_clk);
        end
    endtask : run

    initial begin
        int unused;
        unused = $urandom(34);
        reset_dut();
        checking = 1'b1;
        for (int a = 0; a < 24; a += 4) bus_write(5'(a), $urandom);
        for (int a = 0; a < 24; a += 4) check_read(5'(a));
        for (int k = 0; k < 4; k++) begin
            setup(k[1] ? timer8_pwm_pkg::MODE_PC_MAX : timer8_pwm_pkg::MODE_FAST_MAX,
                k[0] ? timer8_pwm_pkg::ACT_INV : timer8_pwm_pkg::ACT_NONINV,
                k[0] ? timer8_pwm_pkg::ACT_INV : timer8_pwm_pkg::ACT_NONINV, 8'h00, 8'hFF);
            run(1100, 100, 1'b0);
        end
        setup(timer8_pwm_pkg::MODE_FAST_MAX, timer8_pwm_pkg::ACT_NONINV,
            timer8_pwm_pkg::ACT_INV, 8'h80, 8'h40);
        run(700, 100, 1'b0);
        bus_write(timer8_pwm_pkg::OFF_CMPB, 32'h000000C0);
        bus_write(timer8_pwm_pkg::OFF_STATUS, 32'h00000001);
        check_read(timer8_pwm_pkg::OFF_STATUS);
        run(700, 50, 1'b1);
        check_read(timer8_pwm_pkg::OFF_COUNT);
        setup(timer8_pwm_pkg::MODE_FAST_MAX, timer8_pwm_pkg::ACT_TOGGLE,
            timer8_pwm_pkg::ACT_TOGGLE, 8'h20, 8'h20);
        run(600, 100, 1'b0);
        setup(timer8_pwm_pkg::MODE_FAST_CMPA, timer8_pwm_pkg::ACT_TOGGLE,
            timer8_pwm_pkg::ACT_TOGGLE, 8'h00, 8'h00);
        run(64, 100, 1'b0);
        setup(timer8_pwm_pkg::MODE_FAST_CMPA, timer8_pwm_pkg::ACT_NONINV,
            timer8_pwm_pkg::ACT_INV, 8'h30, 8'h10);
        run(500, 60, 1'b1);
        setup(timer8_pwm_pkg::MODE_PC_MAX, timer8_pwm_pkg::ACT_NONINV, timer8_pwm_pkg::ACT_INV,
            8'h01 + 8'($urandom % 254), 8'h01 + 8'($urandom % 254));
        run(1100, 100, 1'b0);
        bus_write(timer8_pwm_pkg::OFF_STATUS, 32'h00000001);
        check_read(timer8_pwm_pkg::OFF_STATUS);
        run(1100, 70, 1'b1);
        // leaving max mid-slope: the new value waits for top, then the level drops there
        setup(timer8_pwm_pkg::MODE_PC_MAX, timer8_pwm_pkg::ACT_NONINV,
            timer8_pwm_pkg::ACT_NONINV, 8'hFF, 8'h80);
        run(600, 100, 1'b0);
        bus_write(timer8_pwm_pkg::OFF_CMPA, 32'h00000040);
        check_read(timer8_pwm_pkg::OFF_CMPA);
        run(1100, 100, 1'b0);
        setup(timer8_pwm_pkg::MODE_PC_MAX, timer8_pwm_pkg::ACT_INV,
            timer8_pwm_pkg::ACT_NONINV, 8'h40, 8'h20);
        bus_write(timer8_pwm_pkg::OFF_COUNT, 32'h00000090);
        check_read(timer8_pwm_pkg::OFF_COUNT);
        run(700, 100, 1'b0);
        setup(timer8_pwm_pkg::MODE_PC_CMPA, timer8_pwm_pkg::ACT_NONINV,
            timer8_pwm_pkg::ACT_NONINV, 8'h60, 8'h20);
        run(800, 80, 1'b1);
        close_out();
    end
endmodule : tb_timer8_pwm
`default_nettype wire
